// File: core/irqg_pkg.sv
package irqg_pkg;
	// Source count and split
	localparam int NUM_SRC   = 16;
	localparam int NUM_EXT   = 4;
	localparam int NUM_INT   = 11;
	localparam int IDX_W     = 4;
	// Index of the software break source, lowest priority
	localparam logic [3:0] BREAK_IDX = 4'hF;
	// Vector table: index 0 is highest priority, low byte addresses
	localparam logic [15:0] VEC_RESET = 16'hFFFC;
	localparam logic [15:0] VEC_TOP   = 16'hFFFA;
	localparam logic [15:0] VEC_STEP  = 16'h0002;
	localparam logic [15:0] VEC_BREAK = 16'hFFDC;
	localparam logic [15:0] REQ_RST   = 16'h0000;
	localparam logic [15:0] EN_RST    = 16'h0000;
	typedef enum logic [1:0] {
		IRQG_IDLE  = 2'b00,
		IRQG_GRANT = 2'b01,
		IRQG_WAIT  = 2'b10
	} irqg_state_t;
endpackage : irqg_pkg

// File: core/irqg_prio.sv
`timescale 1ns/100ps
module irqg_prio (
	input  wire logic [15:0] qual_i,
	output logic             any_o,
	output logic [3:0]       idx_o
);
	// Lowest index wins
	always_comb begin
		any_o = 1'b0;
		idx_o = 4'h0;
		for (int i = irqg_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (qual_i[i]) begin
				any_o = 1'b1;
				idx_o = 4'(i);
			end
		end
	end
endmodule : irqg_prio

// File: core/irqg_top.sv
// Notes on behaviour
// - Sixteen sources are handled: four pins, eleven peripherals, one break instruction.
// - A maskable source requests only with its request and enable set and disable clear.
// - Software writes set and clear each enable bit, which then holds its value.
// - Software may clear a request bit but writing one never sets it.
// - The break source ignores the disable flag and every enable bit.
// - Simultaneous qualified requests are granted one at a time by fixed priority.
// - On acceptance the disable flag is set and the request cleared.
// - Each source owns a fixed vector pair, reset highest and break lowest.
`timescale 1ns/100ps
module irqg_top (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic [3:0]  ext_evt_i,
	input  wire logic [10:0] per_evt_i,
	input  wire logic        software_break_instruction_i,
	input  wire logic        en_wr_i,
	input  wire logic [15:0] en_wdata_i,
	input  wire logic        req_clr_wr_i,
	input  wire logic [15:0] req_wdata_i,
	input  wire logic        idis_set_i,
	input  wire logic        idis_clr_i,
	input  wire logic        accept_i,
	output logic             irq_o,
	output logic [3:0]       irq_idx_o,
	output logic [15:0]      vec_addr_o,
	output logic             idis_o,
	output logic [15:0]      req_o,
	output logic [15:0]      en_o
);
	////////////////////////////////////////////////////////////////////////
	logic [3:0]  ext_s1_reg;
	logic [3:0]  ext_s2_reg;
	logic [3:0]  ext_s3_reg;
	logic [15:0] req_reg;
	logic [15:0] req_next;
	logic [15:0] en_reg;
	logic [15:0] en_next;
	logic        idis_reg;
	logic        idis_next;
	logic        irq_reg;
	logic        irq_next;
	logic [3:0]  idx_reg;
	logic [3:0]  idx_next;
	logic [15:0] vec_reg;
	logic [15:0] vec_next;
	logic [15:0] evt;
	logic [15:0] qual;
	logic        any;
	logic [3:0]  win;
	irqg_pkg::irqg_state_t st_reg;
	irqg_pkg::irqg_state_t st_next;

	// Pins pass two flops; third stage only for edge detection
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ext_s1_reg <= 4'h0;
			ext_s2_reg <= 4'h0;
			ext_s3_reg <= 4'h0;
		end else begin
			ext_s1_reg <= ext_evt_i;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	assign evt = {software_break_instruction_i, per_evt_i, ext_s2_reg & ~ext_s3_reg};

	////////////////////////////////////////////////////////////////////////
	// maskable qualification
	always_comb begin
		qual = req_reg & en_reg & {16{~idis_reg}};
		qual[irqg_pkg::BREAK_IDX] = req_reg[irqg_pkg::BREAK_IDX];
	end

	irqg_prio u_prio (
		.qual_i (qual),
		.any_o  (any),
		.idx_o  (win)
	);

	always_comb begin
		req_next  = req_reg;
		en_next   = en_reg;
		idis_next = idis_reg;
		st_next   = st_reg;
		irq_next  = irq_reg;
		idx_next  = idx_reg;
		vec_next  = vec_reg;
		if (en_wr_i) begin
			en_next = en_wdata_i;
		end
		if (req_clr_wr_i) begin
			req_next = req_next & req_wdata_i;
		end
		if (idis_set_i) begin
			idis_next = 1'b1;
		end else if (idis_clr_i) begin
			idis_next = 1'b0;
		end
		unique case (st_reg)
			irqg_pkg::IRQG_IDLE: begin
				if (any) begin
					st_next  = irqg_pkg::IRQG_GRANT;
					irq_next = 1'b1;
					idx_next = win;
					vec_next = irqg_pkg::VEC_TOP - (16'(win) * irqg_pkg::VEC_STEP);
				end
			end
			irqg_pkg::IRQG_GRANT: begin
				if (accept_i) begin
					idis_next          = 1'b1;
					req_next[idx_reg]  = 1'b0;
					irq_next           = 1'b0;
					st_next            = irqg_pkg::IRQG_WAIT;
				end else if (!qual[idx_reg]) begin
					irq_next = 1'b0;
					st_next  = irqg_pkg::IRQG_IDLE;
				end
			end
			irqg_pkg::IRQG_WAIT: begin
				st_next = irqg_pkg::IRQG_IDLE;
			end
			default: begin
				st_next = irqg_pkg::IRQG_IDLE;
			end
		endcase
		req_next = req_next | evt;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			req_reg  <= irqg_pkg::REQ_RST;
			en_reg   <= irqg_pkg::EN_RST;
			idis_reg <= 1'b1;
			st_reg   <= irqg_pkg::IRQG_IDLE;
			irq_reg  <= 1'b0;
			idx_reg  <= 4'h0;
			vec_reg  <= irqg_pkg::VEC_RESET;
		end else begin
			req_reg  <= req_next;
			en_reg   <= en_next;
			idis_reg <= idis_next;
			st_reg   <= st_next;
			irq_reg  <= irq_next;
			idx_reg  <= idx_next;
			vec_reg  <= vec_next;
		end
	end

	assign irq_o      = irq_reg;
	assign irq_idx_o  = idx_reg;
	assign vec_addr_o = vec_reg;
	assign idis_o     = idis_reg;
	assign req_o      = req_reg;
	assign en_o       = en_reg;

	////////////////////////////////////////////////////////////////////////
	// masked source quiet
	mask_block_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_IDLE && idis_reg && !req_reg[irqg_pkg::BREAK_IDX])
		|=> !irq_reg) else $error("masked request granted");
	en_block_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_IDLE
		&& (req_reg & (en_reg | (16'h0001 << irqg_pkg::BREAK_IDX))) == 16'h0000)
		|=> !irq_reg) else $error("disabled request granted");
	break_unmask_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_IDLE && req_reg == 16'h8000 && idis_reg)
		|=> (irq_reg && idx_reg == irqg_pkg::BREAK_IDX && vec_reg == irqg_pkg::VEC_BREAK))
		else $error("break blocked");
	break_grant_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_IDLE && req_reg[irqg_pkg::BREAK_IDX]) |=> irq_reg)
		else $error("break not granted");
	no_sw_set_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!req_reg[0] && evt[0] == 1'b0) |=> !req_reg[0]) else $error("request set without event");
	sw_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		req_clr_wr_i |=> ((req_reg & ~$past(req_wdata_i) & ~$past(evt)) == 16'h0000))
		else $error("request clear lost");
	evt_sets_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(evt != 16'h0000) |=> ((req_reg & $past(evt)) == $past(evt)))
		else $error("event lost");
	en_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		en_wr_i |=> en_reg == $past(en_wdata_i)) else $error("enable write lost");
	en_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!en_wr_i |=> $stable(en_reg)) else $error("enable changed without write");
	accept_fx_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_GRANT && accept_i && !evt[idx_reg])
		|=> (idis_reg && !req_reg[$past(idx_reg)] && !irq_reg)) else $error("accept wrong");
	prio_order_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_IDLE && qual != 16'h0000) |=> (irq_reg
		&& ($past(qual) & (16'h0001 << idx_reg)) != 16'h0000
		&& ($past(qual) & ((16'h0001 << idx_reg) - 16'h0001)) == 16'h0000))
		else $error("priority wrong");
	wait_quiet_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(st_reg == irqg_pkg::IRQG_WAIT) |=> !irq_reg)
		else $error("grant during wait");
	vec_map_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		irq_reg |-> vec_reg == 16'(irqg_pkg::VEC_TOP - 16'(idx_reg) * irqg_pkg::VEC_STEP))
		else $error("vector mismatch");
endmodule : irqg_top

// File: sim/irqg_core_model.sv
`timescale 1ns/100ps
module irqg_core_model (
	input  wire logic       mclk_i,
	input  wire logic       irq_i,
	input  wire logic [3:0] slow_i,
	output logic            accept_o
);
	logic [3:0] wait_cnt;
	initial begin
		accept_o = 1'b0;
		wait_cnt = 4'h0;
	end
	always @(negedge mclk_i) begin
		accept_o <= 1'b0;
		if (!irq_i || accept_o)
			wait_cnt <= 4'h0;
		else if (wait_cnt < slow_i)
			wait_cnt <= wait_cnt + 4'h1;
		else
			accept_o <= 1'b1;
	end
endmodule : irqg_core_model

// File: sim/tb.sv
`timescale 1ns/100ps
module tb;
	logic        mclk_i, resetn_i, sw_break, en_wr, clr_wr, set_i, clr_i, acc, irq, idis;
	logic [3:0]  ext, idx, slow;
	logic [10:0] per;
	logic [15:0] en_wd, req_wd, vec, req, en;
	int          err_count, checks_done;
	irqg_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .ext_evt_i(ext), .per_evt_i(per),
		.software_break_instruction_i(sw_break), .en_wr_i(en_wr), .en_wdata_i(en_wd),
		.req_clr_wr_i(clr_wr), .req_wdata_i(req_wd), .idis_set_i(set_i), .idis_clr_i(clr_i),
		.accept_i(acc), .irq_o(irq), .irq_idx_o(idx), .vec_addr_o(vec), .idis_o(idis),
		.req_o(req), .en_o(en));
	irqg_core_model core_u (.mclk_i(mclk_i), .irq_i(irq), .slow_i(slow), .accept_o(acc));
	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : pulse
	task automatic wait_irq();
		for (int n = 0; n < 20 && irq !== 1'b1; n++)
			tick(1);
	endtask : wait_irq
	task automatic t_enable();
		en_wd = 16'hA5C3;
		pulse(en_wr);
		chk(en, 16'hA5C3); // enables
		en_wd = 16'h5A3C;
		pulse(en_wr);
		chk(en, 16'h5A3C); // enables
	endtask : t_enable
	task automatic t_mask();
		en_wd = 16'hFFFF;
		pulse(en_wr);
		per = 11'h001;
		tick(1);
		per = 11'h000;
		tick(2);
		chk({15'h0, irq}, 16'h0000); // flag masks
		req_wd = 16'hFFFF;
		pulse(clr_wr);
		chk(req, 16'h0010); // held
		req_wd = 16'hFFEF;
		pulse(clr_wr);
		chk(req, 16'h0000); // cleared
		ext = 4'h2;
		tick(5);
		chk(req, 16'h0002); // pin source
		req_wd = 16'h0000;
		pulse(clr_wr);
		en_wd = 16'h0000;
		pulse(en_wr);
		pulse(clr_i);
		per = 11'h001;
		tick(1);
		per = 11'h000;
		tick(3);
		chk({15'h0, irq}, 16'h0000); // enable masks
		pulse(clr_wr);
	endtask : t_mask
	task automatic t_edge();
		en_wd = 16'h0000;
		pulse(en_wr); // disable first
		ext = 4'h3;
		tick(5);
		chk({irq, req[14:0]}, 16'h0001); // edge while disabled
		req_wd = 16'hFFFE;
		pulse(clr_wr); // clear after change
		en_wd = 16'h0001;
		pulse(en_wr); // re-enable last
		tick(2);
		chk({irq, req[14:0]}, 16'h0000); // no spurious grant
		ext = 4'h2;
		tick(4);
		ext = 4'h3;
		wait_irq();
		chk({idx, vec[11:0]}, 16'h0FFA); // pin grant
	endtask : t_edge
	task automatic t_break();
		pulse(set_i);
		slow = 4'h3;
		pulse(sw_break);
		wait_irq();
		chk({11'h0, irq, idx}, 16'h001F); // unmaskable
		chk(vec, 16'hFFDC); // break vector
		tick(8);
		chk(req, 16'h0000); // request cleared
	endtask : t_break
	task automatic t_prio();
		slow = 4'h0;
		en_wd = 16'hFFFF;
		pulse(en_wr);
		pulse(clr_i);
		per = 11'h401;
		tick(1);
		per = 11'h000;
		wait_irq();
		chk({idx, vec[11:0]}, 16'h4FF2); // first winner
		tick(3);
		chk({idis, req[14:0]}, 16'hC000); // flag set, bit cleared
		pulse(clr_i);
		wait_irq();
		chk({idx, vec[11:0]}, 16'hEFDE); // next winner
	endtask : t_prio
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (2000) @(posedge mclk_i);
		err_count++;
		end_of_test();
	end
	initial begin
		{resetn_i, sw_break, en_wr, clr_wr, set_i, clr_i} = 6'h00;
		{ext, per, slow, en_wd, req_wd} = 51'h0;
		err_count = 0;
		checks_done = 0;
		tick(4);
		resetn_i = 1'b1;
		tick(1);
		chk({irq, idis, req[13:0] | en[13:0]}, 16'h4000); // reset state
		chk(vec, 16'hFFFC); // reset vector
		t_enable();
		t_mask();
		t_edge();
		t_break();
		t_prio();
		end_of_test();
	end
endmodule : tb
